// File: core/arc_pkg.sv
// Package for the converter span and reset control block.
// Assumes a single 250 MHz clock domain and an APB register port.
package arc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;  // Control: span bits
  localparam logic [7:0] STAT_OFS   = 8'h04;  // Status: live state
  localparam logic [7:0] CONV_OFS   = 8'h08;  // Conversion length

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SPAN_A_POS   = 0;   // Span bit of pair A
  localparam int SPAN_B_POS   = 1;   // Span bit of pair B
  localparam int SPAN_C_POS   = 2;   // Span bit of pair C
  localparam int ST_BUSY_POS  = 0;   // Status: busy
  localparam int ST_RST_POS   = 1;   // Status: in reset
  localparam int ST_MODE_POS  = 2;   // Status: software mode
  localparam int ST_HWSP_POS  = 3;   // Status: latched pin span
  localparam int ST_ARM_POS   = 4;   // Status: start pairs armed (3)
  localparam int ST_EFF_POS   = 8;   // Status: effective spans (3)

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam logic        HWSP_RST     = 1'b0;   // Wide span
  localparam int          CLK_MHZ      = 250;
  localparam int          CONV_NS      = 3000;   // Default conversion
  localparam logic [15:0] CONV_CYC     =
    16'((CONV_NS * CLK_MHZ) / 1000);
  localparam logic [31:0] BAD_ADDR_RD  = 32'h0;

endpackage : arc_pkg

// File: core/arc_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is asynchronous to clk.
module arc_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] INI = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;   // First stage, read by s2 only
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;    // Filtered output
  } arc_sync_st_t;

  arc_sync_st_t st_q;
  arc_sync_st_t st_d;

  // Next state: accept a change once stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.o[i] = st_q.s3[i];
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{s1: INI, s2: INI, s3: INI, o: INI};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.o;

endmodule // arc_sync

// File: core/arc_ctrl.sv
// Span selection, device reset and conversion sequencing for a
// six-channel converter organised as three pairs.
// Assumes asynchronous pins from a host and an APB master on clk.

// Functional notes
// [RQ1] Pin high at busy fall: narrow span
// [RQ2] Pin low at busy fall: wide span
// [RQ3] Software mode: spans from control bits
// [RQ4] Reset pin high resets in any mode
// [RQ5] Software reset aborts, clears control register
// [RQ6] Hardware reset reloads from select pins
// [RQ7] Host pulses reset after power-up
// [RQ8] Strobes may stay high through reset
// [RQ9] Strobe low in reset needs full pulse
// [RQ10] Host may reset between hardware conversions
// [RQ11] Busy high while converting, falls at end
module arc_ctrl (
  input  wire logic        clk,
  input  wire logic        nrst,
  // Pins from the host
  input  wire logic        span_sel,       // High: narrow span
  input  wire logic        sw_mode,        // High: software mode
  input  wire logic        dev_reset,      // High: reset
  input  wire logic [2:0]  conversion_start_strobe, // Pairs A..C
  // Status pins
  output logic             busy,
  output logic [2:0]       span_narrow,    // Effective span per pair
  output logic [2:0]       sample_pulse,   // Pair sampled this cycle
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pins_s;   // {strobes, reset, mode, span}

  arc_sync #(.W(6), .INI(6'h38)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({conversion_start_strobe, dev_reset, sw_mode, span_sel}),
    .q    (pins_s)
  );

  logic [2:0] strb_s;   // Filtered strobes
  logic       rst_s;    // Filtered reset pin
  logic       mode_s;   // Filtered mode select
  logic       span_s;   // Filtered span pin

  assign strb_s = pins_s[5:3];
  assign rst_s  = pins_s[2];
  assign mode_s = pins_s[1];
  assign span_s = pins_s[0];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum {
    IDLE,
    CONV
  } arc_fsm_t;

  typedef struct packed {
    arc_fsm_t    fsm;        // Conversion sequencer
    logic [15:0] cnt;        // Cycles left in conversion
    logic [15:0] conv_len;   // Programmed conversion length
    logic [2:0]  ctrl;       // Software span bits
    logic        hw_span;    // Span latched at busy fall
    logic        sw_lat;     // Mode latched at reset
    logic [2:0]  strb_prev;  // Strobe history for edges
    logic [2:0]  armed;      // Pair may start on rising edge
    logic [2:0]  in_flight;  // Pairs in current conversion
    logic        busy;
    logic [2:0]  span_out;
    logic [2:0]  smp;
    logic [31:0] rdata;
    logic        ready;
  } arc_st_t;

  arc_st_t st_q;
  arc_st_t st_d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Effective span per pair; software bits win in software mode
  function automatic logic [2:0] eff_span(input logic swm,
                                          input logic [2:0] c,
                                          input logic hw);
    eff_span = swm ? c : {3{hw}};  // [RQ3]
  endfunction

  logic [2:0] rise;     // Strobe rising edges
  logic [2:0] fall;     // Strobe falling edges
  logic       apb_acc;  // APB access phase

  assign rise    = strb_s & ~st_q.strb_prev;
  assign fall    = ~strb_s & st_q.strb_prev;
  assign apb_acc = psel & penable & ~st_q.ready;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.strb_prev = strb_s;
    st_d.smp       = 3'h0;
    st_d.ready     = 1'b0;

    // Arm a pair once its strobe has been seen falling outside reset
    st_d.armed = st_q.armed | fall;  // [RQ9]

    unique case (st_q.fsm)
      IDLE: begin
        // Start on a rising edge of any armed pair
        if ((rise & st_q.armed) != 3'h0) begin
          st_d.fsm       = CONV;
          st_d.in_flight = rise & st_q.armed;
          st_d.smp       = rise & st_q.armed;
          st_d.cnt       = st_q.conv_len;
          st_d.busy      = 1'b1;  // [RQ11]
        end
      end
      CONV: begin
        // Later pairs may join while converting
        st_d.in_flight = st_q.in_flight | (rise & st_q.armed);
        st_d.smp       = rise & st_q.armed & ~st_q.in_flight;
        if (st_q.cnt <= 16'h1) begin
          st_d.fsm  = IDLE;
          st_d.busy = 1'b0;  // [RQ11]
          // A pair rising on the last cycle is not sampled: no
          // conversion would stand behind it once busy has fallen
          st_d.smp  = 3'h0;  // [RQ11]
          // Busy falls now: pin span sampled for the next conversion
          st_d.hw_span = span_s;  // [RQ1] [RQ2]
        end else begin
          st_d.cnt = st_q.cnt - 16'h1;
        end
      end
    endcase

    // APB: one wait state, registered answer
    if (apb_acc) begin
      st_d.ready = 1'b1;
      st_d.rdata = arc_pkg::BAD_ADDR_RD;
      unique case (paddr)
        arc_pkg::CTRL_OFS: begin
          if (pwrite) begin
            st_d.ctrl = pwdata[2:0];
          end
          st_d.rdata[2:0] = st_q.ctrl;
        end
        arc_pkg::STAT_OFS: begin
          st_d.rdata[arc_pkg::ST_BUSY_POS] = st_q.busy;
          st_d.rdata[arc_pkg::ST_RST_POS]  = rst_s;
          st_d.rdata[arc_pkg::ST_MODE_POS] = st_q.sw_lat;
          st_d.rdata[arc_pkg::ST_HWSP_POS] = st_q.hw_span;
          st_d.rdata[arc_pkg::ST_ARM_POS +: 3] = st_q.armed;
          st_d.rdata[arc_pkg::ST_EFF_POS +: 3] = st_q.span_out;
        end
        arc_pkg::CONV_OFS: begin
          if (pwrite && pwdata[15:0] != 16'h0) begin
            st_d.conv_len = pwdata[15:0];
          end
          st_d.rdata[15:0] = st_q.conv_len;
        end
        default: begin
          // Unmapped: reads zero, writes ignored
        end
      endcase
    end

    // Device reset from the pin overrides sequencing
    if (rst_s) begin  // [RQ4]
      st_d.fsm       = IDLE;  // [RQ5]
      st_d.busy      = 1'b0;
      st_d.cnt       = 16'h0;
      st_d.in_flight = 3'h0;
      st_d.smp       = 3'h0;
      st_d.ctrl      = arc_pkg::CTRL_RST;  // [RQ5]
      // Reload configuration from the select pins
      st_d.sw_lat    = mode_s;  // [RQ6]
      st_d.hw_span   = span_s;  // [RQ6]
      // A strobe held low needs a fresh falling edge afterwards;
      // one held high stays armed so its next pulse just works
      st_d.armed     = strb_s;  // [RQ8] [RQ9]
    end

    st_d.span_out = eff_span(st_d.sw_lat, st_d.ctrl, st_d.hw_span);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{fsm: IDLE, cnt: 16'h0, conv_len: arc_pkg::CONV_CYC,
                ctrl: arc_pkg::CTRL_RST, hw_span: arc_pkg::HWSP_RST,
                sw_lat: 1'b0, strb_prev: 3'h7, armed: 3'h0,
                in_flight: 3'h0, busy: 1'b0, span_out: 3'h0,
                smp: 3'h0, rdata: 32'h0, ready: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops except pslverr, tied low
  // ---------------------------------------------------------------
  assign busy         = st_q.busy;
  assign span_narrow  = st_q.span_out;
  assign sample_pulse = st_q.smp;
  assign prdata       = st_q.rdata;
  assign pready       = st_q.ready;
  assign pslverr      = 1'b0;

endmodule // arc_ctrl

// File: tb/arc_chk.sv
// Port checker for the span and reset control block.
// Assumes one clock domain; bound from the bench top.
module arc_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       span_sel,
  input wire logic       sw_mode,
  input wire logic       dev_reset,
  input wire logic       busy,
  input wire logic [2:0] span_narrow,
  input wire logic [2:0] sample_pulse,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rc_q;    // Cycles the reset pin has been high
  logic [3:0] sc_q;    // Cycles the span pin has been steady
  logic       mode_q;  // Mode the block should have latched
  logic       span_q;  // Span pin one cycle ago

  // Counters saturate so long holds never wrap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rc_q   <= 4'h0;
      sc_q   <= 4'h0;
      mode_q <= 1'b0;
      span_q <= 1'b0;
    end else begin
      span_q <= span_sel;
      if (!dev_reset) begin
        rc_q <= 4'h0;
      end else if (rc_q != 4'hf) begin
        rc_q <= rc_q + 4'h1;
      end
      if (span_sel != span_q) begin
        sc_q <= 4'h0;
      end else if (sc_q != 4'hf) begin
        sc_q <= sc_q + 4'h1;
      end
      if (rc_q == 4'h4) begin
        mode_q <= sw_mode;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_hw_narrow;
    $fell(busy) && !mode_q && sc_q > 4'h8 && span_sel
      |-> span_narrow == 3'h7;
  endproperty
  property p_hw_wide;
    $fell(busy) && !mode_q && sc_q > 4'h8 && !span_sel
      |-> span_narrow == 3'h0;
  endproperty
  property p_rst_quiet;
    rc_q > 4'h6 |-> !busy && sample_pulse == 3'h0;
  endproperty
  property p_sw_clear;
    rc_q > 4'h6 && mode_q |-> span_narrow == 3'h0;
  endproperty
  property p_hw_load;
    rc_q > 4'h6 && !mode_q && sc_q > 4'h8 |-> span_narrow == {3{span_sel}};
  endproperty
  property p_pulse_busy;
    sample_pulse != 3'h0
      |-> busy ##1 (sample_pulse & $past(sample_pulse)) == 3'h0;
  endproperty
  property p_busy_cause;
    $rose(busy) |-> sample_pulse != 3'h0;
  endproperty
  property p_rdy_wait;
    psel && penable && !pready |=> pready;
  endproperty
  property p_rdy_one;
    pready |=> !pready && !pslverr;
  endproperty

  a_hw_narrow: assert property (p_hw_narrow)
    else $error("narrow span not taken at busy fall");
  a_hw_wide: assert property (p_hw_wide)
    else $error("wide span not taken at busy fall");
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("activity while reset held");
  a_sw_clear: assert property (p_sw_clear)
    else $error("span bits not cleared by reset");
  a_hw_load: assert property (p_hw_load)
    else $error("span not loaded from pin in reset");
  a_pulse_busy: assert property (p_pulse_busy)
    else $error("sample pulse without busy or too long");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a sample");
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("no answer one cycle into access");
  a_rdy_one: assert property (p_rdy_one)
    else $error("ready longer than one cycle or error set");

  c_conv: cover property ($fell(busy));
  c_sw: cover property (rc_q > 4'h6 && mode_q);
  c_wr: cover property (pready && pwrite);
endmodule // arc_chk

// File: tb/arc_host.sv
// Host model driving span, mode, reset and start pins.
// Assumes the bench calls its tasks; changes follow rising edges.
module arc_host (
  input  wire logic clk,
  output logic       span_sel,
  output logic       sw_mode,
  output logic       dev_reset,
  output logic [2:0] strb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    span_sel  = 1'b0;
    sw_mode   = 1'b0;
    dev_reset = 1'b0;
    strb      = 3'h7;
  end
  // Reset of 25 cycles, 100 ns; strobes high or low through it
  task automatic reset_pulse(input logic m, input logic lo);
    @(posedge clk);
    sw_mode   <= m;
    strb      <= lo ? 3'h0 : 3'h7;
    dev_reset <= 1'b1;
    repeat (25) @(posedge clk);
    dev_reset <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic span(input logic v);
    @(posedge clk);
    span_sel <= v;
    repeat (12) @(posedge clk);
  endtask
  // Falling edge first only when f is set, then the rising edge
  task automatic pulse(input logic [2:0] m, input logic f);
    @(posedge clk);
    strb <= f ? (strb & ~m) : strb;
    repeat (8) @(posedge clk);
    strb <= strb | m;
  endtask
endmodule // arc_host

// File: tb/tb_arc_ctrl.sv
// Bench for the span and reset control block: APB and pin tasks.
// Assumes the checker is bound below; spans 1 = narrow.
module tb_arc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, busy;
  logic        span_sel, sw_mode, dev_reset;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  span_narrow, sample_pulse, strb;
  int          n_errors, num_checks, len;

  arc_host host (.clk(clk), .span_sel(span_sel), .sw_mode(sw_mode),
    .dev_reset(dev_reset), .strb(strb));
  arc_ctrl dut (.clk(clk), .nrst(nrst), .span_sel(span_sel),
    .sw_mode(sw_mode), .dev_reset(dev_reset),
    .conversion_start_strobe(strb), .busy(busy),
    .span_narrow(span_narrow), .sample_pulse(sample_pulse),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      tally_and_finish();
    end
  endtask
  // Start pairs m and measure busy; len stays 0 if none starts
  task automatic conv(input logic [2:0] m, input logic f);
    int n;
    host.pulse(m, f);
    n = 0;
    len = 0;
    while (busy !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    while (busy === 1'b1 && len < 900) begin
      @(posedge clk);
      len++;
    end
    if (len >= 900) begin
      chk(32'h1, 32'h0);
      tally_and_finish();
    end
  endtask
  // Short conversions keep the run brief
  task automatic do_reset(input logic m, input logic lo);
    host.reset_pulse(m, lo);
    apb(1'b1, arc_pkg::CONV_OFS, 32'h5, rd);
  endtask

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    n_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    host.span(1'b1);
    do_reset(1'b0, 1'b0);
    chk(32'(span_narrow), 32'h7);
    apb(1'b0, arc_pkg::STAT_OFS, 32'h0, rd);
    chk(rd, 32'h778);
    apb(1'b0, arc_pkg::CONV_OFS, 32'h0, rd);
    chk(rd, 32'h5);
    host.span(1'b0);
    conv(3'h7, 1'b1);
    chk(32'(span_narrow), 32'h0);
    chk(len, 5);
    host.span(1'b1);
    conv(3'h1, 1'b1);
    chk(32'(span_narrow), 32'h7);
    $display("test hardware spans done");
    do_reset(1'b1, 1'b0);
    chk(32'(span_narrow), 32'h0);
    apb(1'b1, arc_pkg::CTRL_OFS, 32'h5, rd);
    apb(1'b1, 8'h0c, 32'h2, rd);
    apb(1'b0, 8'h0c, 32'h0, rd);
    chk(rd, 32'h0);
    conv(3'h2, 1'b1);
    chk(32'(span_narrow), 32'h5);
    apb(1'b1, arc_pkg::CONV_OFS, 32'hc8, rd);
    host.pulse(3'h1, 1'b1);
    repeat (10) @(posedge clk);
    chk(32'(busy), 32'h1);
    host.reset_pulse(1'b1, 1'b0);
    chk(32'(busy), 32'h0);
    apb(1'b0, arc_pkg::CTRL_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test software mode done");
    do_reset(1'b0, 1'b1);
    conv(3'h4, 1'b0);
    chk(len, 0);
    conv(3'h4, 1'b1);
    chk(len, 5);
    $display("test start after reset done");
    tally_and_finish();
  end
endmodule // tb_arc_ctrl

bind arc_ctrl arc_chk u_chk (.clk(clk), .nrst(nrst), .span_sel(span_sel),
  .sw_mode(sw_mode), .dev_reset(dev_reset), .busy(busy),
  .span_narrow(span_narrow), .sample_pulse(sample_pulse), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr));
